// [verilog/mdr_pkg.sv]
/*
  Constants for the motion sensor register block: offsets, field positions,
  reset values and widths shared by the register file and the detectors.
  Assumes nothing of its surroundings.
*/
package mdr_pkg;
  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] MDR_Y_ACCEL_LOW = 8'h10;
  localparam logic [7:0] MDR_Y_ACCEL_HIGH = 8'h11;
  localparam logic [7:0] MDR_Z_ACCEL_LOW = 8'h12;
  localparam logic [7:0] MDR_Z_ACCEL_HIGH = 8'h13;
  localparam logic [7:0] MDR_TEMPERATURE_LOW = 8'h14;
  localparam logic [7:0] MDR_TEMPERATURE_HIGH = 8'h15;
  localparam logic [7:0] MDR_RESET_COMMAND = 8'h1f;
  localparam logic [7:0] MDR_MOTION_THRESHOLD_LOW = 8'h20;
  localparam logic [7:0] MDR_MOTION_THRESHOLD_HIGH = 8'h21;
  localparam logic [7:0] MDR_MOTION_SAMPLE_COUNT = 8'h22;
  localparam logic [7:0] MDR_STILL_THRESHOLD_LOW = 8'h23;
  localparam logic [7:0] MDR_STILL_THRESHOLD_HIGH = 8'h24;
  localparam logic [7:0] MDR_STILL_COUNT_LOW = 8'h25;
  localparam logic [7:0] MDR_STILL_COUNT_HIGH = 8'h26;

  // ----------------------------------------------------------------------
  // Codes, reset values and field layout
  // ----------------------------------------------------------------------
  localparam logic [7:0] MDR_SOFT_RESET_CODE = 8'h52;
  localparam logic [7:0] MDR_REG_RESET = 8'h00;
  localparam logic [7:0] MDR_READ_ZERO = 8'h00;
  localparam int MDR_SAMPLE_W = 12;
  localparam int MDR_SIGN_BIT = 11;
  localparam int MDR_SIGN_COPIES = 4;
  localparam int MDR_THRESH_W = 11;
  localparam int MDR_THRESH_HIGH_W = 3;
  localparam int MDR_COUNT_W = 16;
  localparam logic [MDR_COUNT_W-1:0] MDR_COUNT_ONE = 16'h0001;
endpackage

// [verilog/mdr_detect.sv]
/*
  One consecutive-sample detector: counts an unbroken run of qualifying
  samples and pulses an event when the run reaches the programmed length.
  Assumes sample_valid is a one-cycle pulse on core_clk, once per sample.
*/
`timescale 1ns/1ps
`default_nettype none
module mdr_detect
  import mdr_pkg::*;
#(
  parameter int COUNT_W = MDR_COUNT_W
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clear,
  input wire logic enable,
  input wire logic sample_valid,
  input wire logic qualify,
  input wire logic single_shot,
  input wire logic [COUNT_W-1:0] target,
  output logic [COUNT_W-1:0] run_q,
  output logic event_q
);
  logic [COUNT_W-1:0] goal;
  logic [COUNT_W-1:0] run_d;
  logic hit;

  // Zero acts as one; single-shot ignores the programmed length
  always_comb begin
    if (single_shot || target == '0) begin
      goal = COUNT_W'(1);
    end else begin
      goal = target;
    end
  end

  // Saturating at the goal so one unbroken run fires only once
  always_comb begin
    run_d = run_q;
    hit = 1'b0;
    if (!enable) begin
      run_d = '0;
    end else if (sample_valid) begin
      if (!qualify) begin
        run_d = '0;
      end else if (run_q < goal) begin
        run_d = run_q + COUNT_W'(1);
        hit = (run_d == goal);
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      run_q <= '0;
    end else if (clear) begin
      run_q <= '0;
    end else begin
      run_q <= run_d;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      event_q <= 1'b0;
    end else begin
      event_q <= hit && !clear;
    end
  end
endmodule
`default_nettype wire

// [verilog/mdr_regs.sv]
/*
  Register file and activity/inactivity detection of a three-axis motion
  sensor: result registers, soft reset command, thresholds and timers.
  Assumes the serial front end delivers decoded one-cycle read and write
  strobes on core_clk, and that sample data arrives already synchronous.
*/
// How it works
// - Low result register holds bits 7..0, high register bits 11..8.
// - High result bits 15..12 repeat bit 11 as sign copies.
// - Temperature is signed 12-bit, top four bits follow its sign.
// - Writing 0x52 to reset command clears all settings, enters standby.
// - After soft reset the interrupt pins float, held by keepers.
// - Reset command register is write only; reads return zero.
// - Motion compares each sample magnitude with 11-bit motion threshold.
// - Thresholds: low register bits 7..0, high register low three bits.
// - Thresholds are raw codes, scaling with the selected range.
// - Motion event needs that many consecutive samples over threshold.
// - Motion sample count of zero behaves like one.
// - Wake-up mode ignores motion count; one sample suffices.
// - Stillness compares each sample magnitude with 11-bit threshold.
// - Still event needs the 16-bit count of samples all under.
// - Still count is low byte plus high byte, up to 0xFFFF.
// - Still count of zero behaves like one.
// - Both timers advance once per output sample.
// - Config error sets at power-up and soft reset, clears on write.
// - Each detector runs only while its own enable is set.
`timescale 1ns/1ps
`default_nettype none
module mdr_regs
  import mdr_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_q,
  output logic reg_rvalid_q,
  input wire logic sample_valid,
  input wire logic [MDR_SAMPLE_W-1:0] x_sample,
  input wire logic [MDR_SAMPLE_W-1:0] y_sample,
  input wire logic [MDR_SAMPLE_W-1:0] z_sample,
  input wire logic [MDR_SAMPLE_W-1:0] temp_sample,
  input wire logic motion_detect_enable,
  input wire logic still_detect_enable,
  input wire logic wake_mode,
  input wire logic measure_start,
  input wire logic [1:0] int_mapped,
  output logic motion_event,
  output logic still_event,
  output logic config_error_q,
  output logic standby_q,
  output logic [1:0] int_out,
  output logic [1:0] int_oe_q
);
  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  logic [MDR_SAMPLE_W-1:0] y_q;
  logic [MDR_SAMPLE_W-1:0] z_q;
  logic [MDR_SAMPLE_W-1:0] temp_q;
  logic [7:0] motion_thr_low_q;
  logic [7:0] motion_thr_high_q;
  logic [7:0] motion_count_q;
  logic [7:0] still_thr_low_q;
  logic [7:0] still_thr_high_q;
  logic [7:0] still_count_low_q;
  logic [7:0] still_count_high_q;
  logic [7:0] rdata_d;
  logic soft_reset;
  logic motion_run;
  logic still_run;
  logic [MDR_THRESH_W-1:0] motion_threshold;
  logic [MDR_THRESH_W-1:0] still_threshold;
  logic [MDR_COUNT_W-1:0] still_sample_count;
  logic [MDR_SAMPLE_W-1:0] x_mag;
  logic [MDR_SAMPLE_W-1:0] y_mag;
  logic [MDR_SAMPLE_W-1:0] z_mag;
  logic motion_qualify;
  logic still_qualify;
  logic [MDR_COUNT_W-1:0] motion_run_q;
  logic [MDR_COUNT_W-1:0] still_run_q;

  // Magnitude of a signed code; -2048 yields 2048 without wrapping
  function automatic logic [MDR_SAMPLE_W-1:0] magnitude(
    input logic [MDR_SAMPLE_W-1:0] value
  );
    if (value[MDR_SIGN_BIT]) begin
      magnitude = MDR_SAMPLE_W'(~value + MDR_SAMPLE_W'(1));
    end else begin
      magnitude = value;
    end
  endfunction

  // High result byte: sign copies above the top four bits
  function automatic logic [7:0] high_byte(
    input logic [MDR_SAMPLE_W-1:0] value
  );
    high_byte = {{MDR_SIGN_COPIES{value[MDR_SIGN_BIT]}}, value[11:8]};
  endfunction

  assign soft_reset = reg_wr && reg_addr == MDR_RESET_COMMAND &&
                      reg_wdata == MDR_SOFT_RESET_CODE;

  // ----------------------------------------------------------------------
  // Result capture
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      y_q <= '0;
      z_q <= '0;
      temp_q <= '0;
    end else if (soft_reset) begin
      y_q <= '0;
      z_q <= '0;
      temp_q <= '0;
    end else if (sample_valid && !standby_q) begin
      y_q <= y_sample;
      z_q <= z_sample;
      temp_q <= temp_sample;
    end
  end

  // ----------------------------------------------------------------------
  // Configuration writes
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      motion_thr_low_q <= MDR_REG_RESET;
      motion_thr_high_q <= MDR_REG_RESET;
      motion_count_q <= MDR_REG_RESET;
      still_thr_low_q <= MDR_REG_RESET;
      still_thr_high_q <= MDR_REG_RESET;
      still_count_low_q <= MDR_REG_RESET;
      still_count_high_q <= MDR_REG_RESET;
    end else if (soft_reset) begin
      motion_thr_low_q <= MDR_REG_RESET;
      motion_thr_high_q <= MDR_REG_RESET;
      motion_count_q <= MDR_REG_RESET;
      still_thr_low_q <= MDR_REG_RESET;
      still_thr_high_q <= MDR_REG_RESET;
      still_count_low_q <= MDR_REG_RESET;
      still_count_high_q <= MDR_REG_RESET;
    end else if (reg_wr) begin
      unique case (reg_addr)
        MDR_MOTION_THRESHOLD_LOW: begin
          motion_thr_low_q <= reg_wdata;
        end
        MDR_MOTION_THRESHOLD_HIGH: begin
          motion_thr_high_q <= reg_wdata;
        end
        MDR_MOTION_SAMPLE_COUNT: begin
          motion_count_q <= reg_wdata;
        end
        MDR_STILL_THRESHOLD_LOW: begin
          still_thr_low_q <= reg_wdata;
        end
        MDR_STILL_THRESHOLD_HIGH: begin
          still_thr_high_q <= reg_wdata;
        end
        MDR_STILL_COUNT_LOW: begin
          still_count_low_q <= reg_wdata;
        end
        MDR_STILL_COUNT_HIGH: begin
          still_count_high_q <= reg_wdata;
        end
        default: begin
        end
      endcase
    end
  end

  // Soft reset re-raises the flag, so it wins over its own write
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      config_error_q <= 1'b1;
    end else if (soft_reset) begin
      config_error_q <= 1'b1;
    end else if (reg_wr) begin
      config_error_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      standby_q <= 1'b1;
    end else if (soft_reset) begin
      standby_q <= 1'b1;
    end else if (measure_start) begin
      standby_q <= 1'b0;
    end
  end

  // Pins float until the mapping logic asks for them again
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      int_oe_q <= 2'b00;
    end else if (soft_reset) begin
      int_oe_q <= 2'b00;
    end else begin
      int_oe_q <= int_mapped;
    end
  end

  assign int_out = {still_event, motion_event};

  // ----------------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------------
  always_comb begin
    unique case (reg_addr)
      MDR_Y_ACCEL_LOW: rdata_d = y_q[7:0];
      MDR_Y_ACCEL_HIGH: rdata_d = high_byte(y_q);
      MDR_Z_ACCEL_LOW: rdata_d = z_q[7:0];
      MDR_Z_ACCEL_HIGH: rdata_d = high_byte(z_q);
      MDR_TEMPERATURE_LOW: rdata_d = temp_q[7:0];
      MDR_TEMPERATURE_HIGH: rdata_d = high_byte(temp_q);
      MDR_RESET_COMMAND: rdata_d = MDR_READ_ZERO;
      MDR_MOTION_THRESHOLD_LOW: rdata_d = motion_thr_low_q;
      MDR_MOTION_THRESHOLD_HIGH: rdata_d = motion_thr_high_q;
      MDR_MOTION_SAMPLE_COUNT: rdata_d = motion_count_q;
      MDR_STILL_THRESHOLD_LOW: rdata_d = still_thr_low_q;
      MDR_STILL_THRESHOLD_HIGH: rdata_d = still_thr_high_q;
      MDR_STILL_COUNT_LOW: rdata_d = still_count_low_q;
      MDR_STILL_COUNT_HIGH: rdata_d = still_count_high_q;
      default: rdata_d = MDR_READ_ZERO;
    endcase
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      reg_rdata_q <= MDR_READ_ZERO;
      reg_rvalid_q <= 1'b0;
    end else begin
      reg_rvalid_q <= reg_rd;
      if (reg_rd) begin
        reg_rdata_q <= rdata_d;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Detection
  // ----------------------------------------------------------------------
  // Raw codes, so the g value moves with the range setting
  assign motion_threshold = {motion_thr_high_q[MDR_THRESH_HIGH_W-1:0],
                             motion_thr_low_q};
  assign still_threshold = {still_thr_high_q[MDR_THRESH_HIGH_W-1:0],
                            still_thr_low_q};
  assign still_sample_count = {still_count_high_q, still_count_low_q};

  assign x_mag = magnitude(x_sample);
  assign y_mag = magnitude(y_sample);
  assign z_mag = magnitude(z_sample);

  assign motion_qualify = x_mag > {1'b0, motion_threshold} ||
                          y_mag > {1'b0, motion_threshold} ||
                          z_mag > {1'b0, motion_threshold};
  assign still_qualify = x_mag < {1'b0, still_threshold} &&
                         y_mag < {1'b0, still_threshold} &&
                         z_mag < {1'b0, still_threshold};

  assign motion_run = motion_detect_enable && !standby_q;
  assign still_run = still_detect_enable && !standby_q;

  mdr_detect #(
    .COUNT_W(MDR_COUNT_W)
  ) u_motion (
    .core_clk(core_clk),
    .reset(reset),
    .clear(soft_reset),
    .enable(motion_run),
    .sample_valid(sample_valid),
    .qualify(motion_qualify),
    .single_shot(wake_mode),
    .target({8'h00, motion_count_q}),
    .run_q(motion_run_q),
    .event_q(motion_event)
  );

  mdr_detect #(
    .COUNT_W(MDR_COUNT_W)
  ) u_still (
    .core_clk(core_clk),
    .reset(reset),
    .clear(soft_reset),
    .enable(still_run),
    .sample_valid(sample_valid),
    .qualify(still_qualify),
    .single_shot(1'b0),
    .target(still_sample_count),
    .run_q(still_run_q),
    .event_q(still_event)
  );

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  AST_Y_HIGH_SIGN: assert property (
    reg_rd && reg_addr == MDR_Y_ACCEL_HIGH |=>
      reg_rvalid_q && reg_rdata_q == {{4{$past(y_q[11])}}, $past(y_q[11:8])})
    else $error("y high byte not sign extended");

  AST_Y_LOW_BYTE: assert property (
    reg_rd && reg_addr == MDR_Y_ACCEL_LOW |=> reg_rdata_q == $past(y_q[7:0]))
    else $error("y low byte wrong");

  AST_TEMP_TOP: assert property (
    reg_rd && reg_addr == MDR_TEMPERATURE_HIGH |=>
      reg_rdata_q[7:4] == 4'h0 || reg_rdata_q[7:4] == 4'hf)
    else $error("temperature top bits mixed");

  AST_SOFT_CLEAR: assert property (
    soft_reset |=> standby_q && motion_count_q == 8'h00 &&
      still_count_high_q == 8'h00 && motion_run_q == 16'h0000)
    else $error("soft reset left settings");

  AST_PINS_FLOAT: assert property (
    soft_reset |=> int_oe_q == 2'b00)
    else $error("interrupt pins driven after soft reset");

  AST_RESET_READ_ZERO: assert property (
    reg_rd && reg_addr == MDR_RESET_COMMAND |=> reg_rdata_q == 8'h00)
    else $error("reset command read not zero");

  AST_ZERO_COUNT_ONE: assert property (
    motion_run && motion_count_q == 8'h00 && sample_valid && motion_qualify &&
      motion_run_q == 16'h0000 && !soft_reset |=> motion_event)
    else $error("zero motion count did not act as one");

  AST_WAKE_SINGLE: assert property (
    motion_run && wake_mode && sample_valid && motion_qualify &&
      motion_run_q == 16'h0000 && !soft_reset |=> motion_event)
    else $error("wake mode did not fire on one sample");

  AST_STILL_ZERO_ONE: assert property (
    still_run && still_sample_count == 16'h0000 && sample_valid &&
      still_qualify && still_run_q == 16'h0000 && !soft_reset |=> still_event)
    else $error("zero still count did not act as one");

  AST_RESTART: assert property (
    still_run && sample_valid && !still_qualify && !soft_reset |=>
      still_run_q == 16'h0000 && !still_event)
    else $error("still run not restarted");

  AST_CFG_CLEAR: assert property (
    reg_wr && !soft_reset && !measure_start |=> !config_error_q && $stable(standby_q))
    else $error("config error not cleared by write");

  AST_DISABLED_QUIET: assert property (
    !motion_run |=> !motion_event)
    else $error("motion event while disabled");

  COV_MOTION: cover property (motion_event);
  COV_STILL: cover property (still_event);
  COV_SOFT: cover property (soft_reset ##1 reg_wr);
  COV_RUN: cover property (sample_valid && motion_qualify ##1 motion_run_q > 16'h0001);
endmodule
`default_nettype wire

// [tb/mdr_host.sv]
/*
  Host model of the register port: one-cycle write and read strobes.
  Assumes it is driven from one bench process at a time.
*/
`timescale 1ns/1ps
`default_nettype none
module mdr_host (
  input wire logic core_clk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  // --------------------------------------------------------------------
  // Access task
  // --------------------------------------------------------------------
  // Released bus shows inverted values so stale data is never trusted
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= wr;
    reg_rd <= ~wr;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
endmodule
`default_nettype wire

// [tb/mdr_regs_tb.sv]
/*
  Self-checking bench for mdr_regs: register map, soft reset, result
  layout and both detectors under random samples.
  Assumes mdr_host drives the register port; one 100 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module mdr_regs_tb;
  import mdr_pkg::*;
  logic core_clk, reset, reg_wr, reg_rd, reg_rvalid_q, sample_valid, sv_seen;
  logic motion_detect_enable, still_detect_enable, wake_mode, measure_start;
  logic motion_event, still_event, config_error_q, standby_q;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_q;
  logic [MDR_SAMPLE_W-1:0] x_sample, y_sample, z_sample, temp_sample;
  logic [MDR_SAMPLE_W-1:0] res[3];
  logic [1:0] int_mapped, int_out, int_oe_q, ev_exp;
  logic [7:0] rd_q[$];
  logic [1:0] ev_q[$];
  logic [7:0] amap[14] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h1f,
                           8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26};
  int n_fail = 0, checked = 0, mrun = 0, srun = 0, stby = 1;
  int mthr = 0, sthr = 0, mcnt = 0, scnt = 0;

  mdr_regs mdr_regs_i (.core_clk, .reset, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata_q, .reg_rvalid_q, .sample_valid, .x_sample, .y_sample, .z_sample,
    .temp_sample, .motion_detect_enable, .still_detect_enable, .wake_mode,
    .measure_start, .int_mapped, .motion_event, .still_event, .config_error_q,
    .standby_q, .int_out, .int_oe_q);
  mdr_host mdr_host_i (.core_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // --------------------------------------------------------------------
  // Compare, report and bus tasks
  // --------------------------------------------------------------------
  task automatic chk_data(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t data got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic [1:0] got, input logic [1:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t flags got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    if (n_fail == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    mdr_host_i.access(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rd_q.push_back(e);
    mdr_host_i.access(1'b0, a, 8'h00);
  endtask
  task automatic chk_state(input logic err, input logic sb);
    @(negedge core_clk);
    chk_bit({config_error_q, standby_q}, {err, sb});
  endtask

  // --------------------------------------------------------------------
  // Output monitor: answers and event pulses against the notes
  // --------------------------------------------------------------------
  always @(posedge core_clk) begin
    if (reg_rvalid_q === 1'b1) begin
      if (rd_q.size() > 0) begin
        chk_data(reg_rdata_q, rd_q.pop_front());
      end else begin
        chk_bit(2'b01, 2'b00);
      end
    end
    if (sv_seen && ev_q.size() > 0) begin
      ev_exp = ev_q.pop_front();
    end else begin
      ev_exp = 2'b00;
    end
    chk_bit({still_event, motion_event}, ev_exp);
    chk_bit(int_out, ev_exp);
    sv_seen <= sample_valid;
  end

  // --------------------------------------------------------------------
  // Sample model and stimulus
  // --------------------------------------------------------------------
  function automatic int mag(input logic [MDR_SAMPLE_W-1:0] v);
    return v[MDR_SAMPLE_W-1] ? 4096 - int'(v) : int'(v);
  endfunction
  function automatic logic [MDR_SAMPLE_W-1:0] pick();
    int m;
    m = ($urandom_range(0, 1) ? mthr : sthr) + $urandom_range(0, 4) - 2;
    if (m < 0) m = 0;
    if (m > 2047) m = 2047;
    if ($urandom_range(0, 15) == 0) return 12'h800;
    return $urandom_range(0, 1) ? MDR_SAMPLE_W'(-m) : MDR_SAMPLE_W'(m);
  endfunction
  task automatic send(input logic [MDR_SAMPLE_W-1:0] x, y, z, t);
    logic mq, sq;
    logic [1:0] ev;
    int nm, ns;
    @(posedge core_clk);
    nm = (wake_mode || mcnt == 0) ? 1 : mcnt;
    ns = (scnt == 0) ? 1 : scnt;
    mq = mag(x) > mthr || mag(y) > mthr || mag(z) > mthr;
    sq = mag(x) < sthr && mag(y) < sthr && mag(z) < sthr;
    ev = 2'b00;
    if (stby || !motion_detect_enable || !mq) mrun = 0;
    else if (mrun < nm) begin
      mrun++;
      ev[0] = (mrun == nm);
    end
    if (stby || !still_detect_enable || !sq) srun = 0;
    else if (srun < ns) begin
      srun++;
      ev[1] = (srun == ns);
    end
    if (!stby) res = '{y, z, t};
    ev_q.push_back(ev);
    sample_valid <= 1'b1;
    x_sample <= x;
    y_sample <= y;
    z_sample <= z;
    temp_sample <= t;
    @(posedge core_clk);
    sample_valid <= 1'b0;
    x_sample <= ~x;
    y_sample <= ~y;
    z_sample <= ~z;
    temp_sample <= ~t;
  endtask
  task automatic read_results();
    for (int i = 0; i < 3; i++) begin
      rd(MDR_Y_ACCEL_LOW + 8'(2 * i), res[i][7:0]);
      rd(MDR_Y_ACCEL_LOW + 8'(2 * i + 1), {{4{res[i][11]}}, res[i][11:8]});
    end
  endtask
  task automatic setup(input int mt, st, mc, sc);
    mthr = mt;
    sthr = st;
    mcnt = mc;
    scnt = sc;
    wr(MDR_MOTION_THRESHOLD_LOW, 8'(mt));
    wr(MDR_MOTION_THRESHOLD_HIGH, {5'($urandom), 3'(mt >> 8)});
    wr(MDR_MOTION_SAMPLE_COUNT, 8'(mc));
    wr(MDR_STILL_THRESHOLD_LOW, 8'(st));
    wr(MDR_STILL_THRESHOLD_HIGH, {5'($urandom), 3'(st >> 8)});
    wr(MDR_STILL_COUNT_LOW, 8'(sc));
    wr(MDR_STILL_COUNT_HIGH, 8'(sc >> 8));
  endtask

  initial begin
    #200000;
    n_fail++;
    test_done();
  end

  initial begin
    logic [7:0] d;
    {reset, sample_valid, sv_seen, measure_start, wake_mode} = 5'b10000;
    {motion_detect_enable, still_detect_enable, int_mapped} = 4'b0011;
    {x_sample, y_sample, z_sample, temp_sample} = '0;
    res = '{default: '0};
    void'($urandom(32'ha8f9_51cb));
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    chk_state(1'b1, 1'b1);
    foreach (amap[i]) rd(amap[i], 8'h00);
    rd(8'h30, 8'h00);
    wr(MDR_Y_ACCEL_LOW, 8'h5a);
    chk_state(1'b0, 1'b1);
    send(12'h123, 12'h9ab, 12'h7ff, 12'h800);
    read_results();
    @(posedge core_clk);
    measure_start <= 1'b1;
    @(posedge core_clk);
    measure_start <= 1'b0;
    stby = 0;
    chk_state(1'b0, 1'b0);
    for (int i = 7; i < 14; i++) begin
      d = 8'($urandom);
      wr(amap[i], d);
      rd(amap[i], d);
    end
    wr(MDR_RESET_COMMAND, 8'h51);
    rd(MDR_RESET_COMMAND, MDR_READ_ZERO);
    rd(amap[13], d);
    for (int b = 0; b < 8; b++) begin
      motion_detect_enable <= 1'b0;
      still_detect_enable <= 1'b0;
      int_mapped <= 2'($urandom);
      setup($urandom_range(1, 2046), $urandom_range(1, 2046), (b + 3) % 4, (b + 1) % 4);
      chk_bit(int_oe_q, int_mapped);
      send(pick(), pick(), pick(), 12'($urandom));
      {wake_mode, still_detect_enable, motion_detect_enable} <= 3'(b);
      repeat (30) send(pick(), pick(), pick(), 12'($urandom));
      read_results();
    end
    motion_detect_enable <= 1'b0;
    still_detect_enable <= 1'b1;
    setup(2047, 2047, 0, 258);
    repeat (260) send(12'h001, 12'hfff, 12'h7fe, 12'h000);
    wr(MDR_RESET_COMMAND, MDR_SOFT_RESET_CODE);
    stby = 1;
    mthr = 0;
    sthr = 0;
    mcnt = 0;
    scnt = 0;
    res = '{default: '0};
    chk_state(1'b1, 1'b1);
    chk_bit(int_oe_q, 2'b00);
    foreach (amap[i]) rd(amap[i], 8'h00);
    send(12'h7ff, 12'h800, 12'h001, 12'h456);
    read_results();
    repeat (4) @(posedge core_clk);
    chk_data(8'(rd_q.size()), 8'h00);
    test_done();
  end
endmodule
`default_nettype wire
